// File: verilog/flash_host_pkg.sv
package flash_host_pkg;
  // Bus geometry, word mode
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;

  // Operations the user may request
  typedef enum logic [1:0] {
    OP_READ = 2'h0,
    OP_PROGRAM = 2'h1,
    OP_SECTOR_ERASE = 2'h2,
    OP_CHIP_ERASE = 2'h3
  } op_t;

  // Completion methods
  typedef enum logic [1:0] {
    METHOD_DATA_POLL = 2'h0,
    METHOD_TOGGLE = 2'h1,
    METHOD_PIN = 2'h2
  } method_t;

  // Command words and unlock addresses
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_1 = 18'h0_0555;
  localparam logic [ADDR_W-1:0] UNLOCK_ADDR_2 = 18'h0_02aa;
  localparam logic [ADDR_W-1:0] RESET_ADDR = 18'h0_0000;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_1 = 16'h00aa;
  localparam logic [DATA_W-1:0] UNLOCK_DATA_2 = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_RESET = 16'h00f0;

  // Last step index of each write sequence
  localparam logic [2:0] PROG_LAST_STEP = 3'h3;
  localparam logic [2:0] ERASE_LAST_STEP = 3'h5;

  // Status bit positions in the data word
  localparam int POLL_BIT = 7;
  localparam int TOGGLE_BIT = 6;
  localparam int TIMEOUT_BIT = 5;

  // Strobe timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int STROBE_NS = 50;
  localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

// File: verilog/flash_bus_cycle.sv
`timescale 1ns/100ps
module flash_bus_cycle (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic write_i,
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr_i,
  input wire logic [flash_host_pkg::DATA_W-1:0] wdata_i,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
  output logic [flash_host_pkg::ADDR_W-1:0] addr_o,
  output logic [flash_host_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o,
  output logic [flash_host_pkg::DATA_W-1:0] rdata_o,
  output logic done_o
);
  import flash_host_pkg::*;

  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_SETUP = 2'b01,
    B_STROBE = 2'b11,
    B_HOLD = 2'b10
  } bus_state_t;

  localparam logic [7:0] STROBE_LAST = 8'(STROBE_CYC - 1);

  bus_state_t st_r, st_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic wr_r, wr_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] dq_r, dq_nxt, rdata_r, rdata_nxt;
  logic oe_r, oe_nxt, ce_n_r, ce_n_nxt, oe_n_r, oe_n_nxt, we_n_r, we_n_nxt;
  logic done_r, done_nxt;

  // One cycle: chip select and address, strobe low, strobe high with data still held
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    addr_nxt = addr_r;
    dq_nxt = dq_r;
    rdata_nxt = rdata_r;
    oe_nxt = oe_r;
    ce_n_nxt = ce_n_r;
    oe_n_nxt = oe_n_r;
    we_n_nxt = we_n_r;
    done_nxt = 1'b0;
    unique case (st_r)
      B_IDLE: begin
        if (start_i) begin
          wr_nxt = write_i;
          addr_nxt = addr_i;
          dq_nxt = wdata_i;
          oe_nxt = write_i;
          ce_n_nxt = 1'b0;
          st_nxt = B_SETUP;
        end
      end
      B_SETUP: begin
        we_n_nxt = ~wr_r;
        oe_n_nxt = wr_r;
        cnt_nxt = STROBE_LAST;
        st_nxt = B_STROBE;
      end
      B_STROBE: begin
        if (cnt_r == 8'h00) begin
          // Sample just as output enable rises, when the read data has settled longest
          if (!wr_r) begin
            rdata_nxt = dq_i;
          end
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          st_nxt = B_HOLD;
        end else begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      B_HOLD: begin
        ce_n_nxt = 1'b1;
        oe_nxt = 1'b0;
        done_nxt = 1'b1;
        st_nxt = B_IDLE;
      end
    endcase
  end

  // Pin and result registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= B_IDLE;
      cnt_r <= 8'h00;
      wr_r <= 1'b0;
      addr_r <= '0;
      dq_r <= '0;
      rdata_r <= '0;
      oe_r <= 1'b0;
      ce_n_r <= 1'b1;
      oe_n_r <= 1'b1;
      we_n_r <= 1'b1;
      done_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      addr_r <= addr_nxt;
      dq_r <= dq_nxt;
      rdata_r <= rdata_nxt;
      oe_r <= oe_nxt;
      ce_n_r <= ce_n_nxt;
      oe_n_r <= oe_n_nxt;
      we_n_r <= we_n_nxt;
      done_r <= done_nxt;
    end
  end

  assign addr_o = addr_r;
  assign dq_o = dq_r;
  assign dq_oe_o = oe_r;
  assign ce_n_o = ce_n_r;
  assign oe_n_o = oe_n_r;
  assign we_n_o = we_n_r;
  assign rdata_o = rdata_r;
  assign done_o = done_r;
endmodule

// File: verilog/flash_status_poller.sv
`timescale 1ns/100ps
// Functional notes
// - Host polls bit seven for program status at the programmed address.
// - Host polls erase status at an address inside a selected sector.
// - After bit seven turns true, take valid data only from next read.
// - Host reads twice, compares toggle; unchanged means done, data next read.
// - Still toggling with timeout flag high: recheck, then fail and reset.
// - Host resuming after other work restarts toggle check from first read.
// - After a timeout failure the host issues the reset command.
module flash_status_poller (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic cmd_valid_i,
  input wire flash_host_pkg::op_t cmd_op_i,
  input wire flash_host_pkg::method_t cmd_method_i,
  input wire logic [flash_host_pkg::ADDR_W-1:0] cmd_addr_i,
  input wire logic [flash_host_pkg::DATA_W-1:0] cmd_data_i,
  input wire logic hold_i,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
  input wire logic ready_busy_n_pin_i,
  output logic cmd_ready_o,
  output logic done_o,
  output logic fail_o,
  output logic [flash_host_pkg::DATA_W-1:0] rdata_o,
  output logic [flash_host_pkg::ADDR_W-1:0] addr_o,
  output logic [flash_host_pkg::DATA_W-1:0] dq_o,
  output logic dq_oe_o,
  output logic ce_n_o,
  output logic oe_n_o,
  output logic we_n_o
);
  import flash_host_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE = 4'b0000,
    S_CMD = 4'b0001,
    S_POLL1 = 4'b0011,
    S_POLL2 = 4'b0010,
    S_RECHK = 4'b0110,
    S_FINAL = 4'b0111,
    S_RSTCMD = 4'b0101,
    S_FINISH = 4'b0100
  } state_t;

  state_t state_r, state_nxt;
  op_t op_r, op_nxt;
  method_t meth_r, meth_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt, bus_addr_r, bus_addr_nxt;
  logic [DATA_W-1:0] data_r, data_nxt, bus_wdata_r, bus_wdata_nxt;
  logic [DATA_W-1:0] prev_r, prev_nxt, rdata_r, rdata_nxt, bus_rdata;
  logic [2:0] step_r, step_nxt;
  logic pend_r, pend_nxt, bus_start_r, bus_start_nxt, bus_write_r, bus_write_nxt;
  logic ready_r, ready_nxt, done_r, done_nxt, fail_r, fail_nxt;
  logic bus_done, exp_bit, poll_ok, toggle_same, last_step;

  // Write sequence word for the current step: address above, data below
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input op_t op, input logic [2:0] step,
      input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    logic [ADDR_W+DATA_W-1:0] w;
    w = {UNLOCK_ADDR_1, UNLOCK_DATA_1};
    unique case (step)
      3'h1, 3'h4: w = {UNLOCK_ADDR_2, UNLOCK_DATA_2};
      3'h2: w = {UNLOCK_ADDR_1, (op == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP};
      3'h3: w = (op == OP_PROGRAM) ? {a, d} : {UNLOCK_ADDR_1, UNLOCK_DATA_1};
      3'h5: w = (op == OP_SECTOR_ERASE) ? {a, CMD_SECTOR_ERASE} : {UNLOCK_ADDR_1, CMD_CHIP_ERASE};
      default: w = {UNLOCK_ADDR_1, UNLOCK_DATA_1};
    endcase
    return w;
  endfunction

  // Expected settled bit seven: written value for program, ones after erase
  assign exp_bit = (op_r == OP_PROGRAM) ? data_r[POLL_BIT] : 1'b1;
  assign poll_ok = (bus_rdata[POLL_BIT] == exp_bit);
  assign toggle_same = (bus_rdata[TOGGLE_BIT] == prev_r[TOGGLE_BIT]);
  assign last_step = (op_r == OP_PROGRAM) ? (step_r == PROG_LAST_STEP) :
    (step_r == ERASE_LAST_STEP);

  // Sequencer: command write, status polling, final data read or reset on failure
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    meth_nxt = meth_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    prev_nxt = prev_r;
    rdata_nxt = rdata_r;
    step_nxt = step_r;
    pend_nxt = pend_r;
    bus_start_nxt = 1'b0;
    bus_write_nxt = bus_write_r;
    bus_addr_nxt = bus_addr_r;
    bus_wdata_nxt = bus_wdata_r;
    ready_nxt = ready_r;
    done_nxt = 1'b0;
    fail_nxt = fail_r;
    if (bus_done) begin
      pend_nxt = 1'b0;
    end
    unique case (state_r)
      S_IDLE: begin
        if (cmd_valid_i && ready_r) begin
          op_nxt = cmd_op_i;
          meth_nxt = cmd_method_i;
          addr_nxt = cmd_addr_i;
          data_nxt = cmd_data_i;
          step_nxt = 3'h0;
          ready_nxt = 1'b0;
          fail_nxt = 1'b0;
          state_nxt = (cmd_op_i == OP_READ) ? S_FINAL : S_CMD;
        end
      end
      S_CMD: begin
        if (!pend_r) begin
          pend_nxt = 1'b1;
          bus_start_nxt = 1'b1;
          bus_write_nxt = 1'b1;
          {bus_addr_nxt, bus_wdata_nxt} = seq_word(op_r, step_r, addr_r, data_r);
        end else if (bus_done) begin
          step_nxt = step_r + 3'h1;
          if (last_step) begin
            state_nxt = S_POLL1;
          end
        end
      end
      S_POLL1: begin
        if (pend_r) begin
          if (bus_done) begin
            prev_nxt = bus_rdata;
            if (meth_r == METHOD_TOGGLE) begin
              state_nxt = S_POLL2;
            end else if (poll_ok) begin
              state_nxt = S_FINAL;
            end else if (bus_rdata[TIMEOUT_BIT]) begin
              state_nxt = S_RECHK;
            end
          end
        end else if (hold_i) begin
          state_nxt = S_POLL1;
        end else if (meth_r == METHOD_PIN) begin
          // Pin is valid once the final write strobe has risen, which it has here
          if (ready_busy_n_pin_i) begin
            state_nxt = S_FINAL;
          end
        end else begin
          pend_nxt = 1'b1;
          bus_start_nxt = 1'b1;
          bus_write_nxt = 1'b0;
          bus_addr_nxt = addr_r;
        end
      end
      S_POLL2: begin
        if (pend_r) begin
          if (bus_done) begin
            prev_nxt = bus_rdata;
            if (toggle_same) begin
              state_nxt = S_FINAL;
            end else if (bus_rdata[TIMEOUT_BIT]) begin
              state_nxt = S_RECHK;
            end
          end
        end else if (hold_i) begin
          // Any earlier sample is stale after a pause, so begin again with two reads
          state_nxt = S_POLL1;
        end else begin
          pend_nxt = 1'b1;
          bus_start_nxt = 1'b1;
          bus_write_nxt = 1'b0;
          bus_addr_nxt = addr_r;
        end
      end
      S_RECHK: begin
        if (pend_r) begin
          if (bus_done) begin
            // The status may have settled just as the timeout flag rose
            if ((meth_r == METHOD_TOGGLE) ? toggle_same : poll_ok) begin
              state_nxt = S_FINAL;
            end else begin
              state_nxt = S_RSTCMD;
            end
          end
        end else begin
          pend_nxt = 1'b1;
          bus_start_nxt = 1'b1;
          bus_write_nxt = 1'b0;
          bus_addr_nxt = addr_r;
        end
      end
      S_FINAL: begin
        if (pend_r) begin
          if (bus_done) begin
            rdata_nxt = bus_rdata;
            state_nxt = S_FINISH;
          end
        end else begin
          pend_nxt = 1'b1;
          bus_start_nxt = 1'b1;
          bus_write_nxt = 1'b0;
          bus_addr_nxt = addr_r;
        end
      end
      S_RSTCMD: begin
        if (pend_r) begin
          if (bus_done) begin
            fail_nxt = 1'b1;
            state_nxt = S_FINISH;
          end
        end else begin
          pend_nxt = 1'b1;
          bus_start_nxt = 1'b1;
          bus_write_nxt = 1'b1;
          bus_addr_nxt = RESET_ADDR;
          bus_wdata_nxt = CMD_RESET;
        end
      end
      S_FINISH: begin
        done_nxt = 1'b1;
        ready_nxt = 1'b1;
        state_nxt = S_IDLE;
      end
    endcase
  end

  // Sequencer registers
  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= S_IDLE;
      op_r <= OP_READ;
      meth_r <= METHOD_DATA_POLL;
      addr_r <= '0;
      data_r <= '0;
      prev_r <= '0;
      rdata_r <= '0;
      step_r <= 3'h0;
      pend_r <= 1'b0;
      bus_start_r <= 1'b0;
      bus_write_r <= 1'b0;
      bus_addr_r <= '0;
      bus_wdata_r <= '0;
      ready_r <= 1'b1;
      done_r <= 1'b0;
      fail_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      meth_r <= meth_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      prev_r <= prev_nxt;
      rdata_r <= rdata_nxt;
      step_r <= step_nxt;
      pend_r <= pend_nxt;
      bus_start_r <= bus_start_nxt;
      bus_write_r <= bus_write_nxt;
      bus_addr_r <= bus_addr_nxt;
      bus_wdata_r <= bus_wdata_nxt;
      ready_r <= ready_nxt;
      done_r <= done_nxt;
      fail_r <= fail_nxt;
    end
  end

  assign cmd_ready_o = ready_r;
  assign done_o = done_r;
  assign fail_o = fail_r;
  assign rdata_o = rdata_r;

  // Pin-level cycle engine; all pin outputs are its flip-flops
  flash_bus_cycle u_bus (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .start_i(bus_start_r),
    .write_i(bus_write_r),
    .addr_i(bus_addr_r),
    .wdata_i(bus_wdata_r),
    .dq_i(dq_i),
    .addr_o(addr_o),
    .dq_o(dq_o),
    .dq_oe_o(dq_oe_o),
    .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o),
    .we_n_o(we_n_o),
    .rdata_o(bus_rdata),
    .done_o(bus_done)
  );

  // Checks on the polling procedure
  sequence s_poll_read;
    bus_start_r && !bus_write_r && (state_r inside {S_POLL1, S_POLL2, S_RECHK});
  endsequence
  sequence s_recheck_fail;
    state_r == S_RECHK && bus_done &&
      ((meth_r == METHOD_TOGGLE) ? !toggle_same : !poll_ok);
  endsequence

  property p_prog_addr;
    @(posedge mclk_i) disable iff (rst_i)
      s_poll_read and (op_r == OP_PROGRAM) |-> ##[1:2] addr_o == addr_r;
  endproperty
  a_prog_addr: assert property (p_prog_addr) else $error("program poll off target");

  property p_erase_addr;
    @(posedge mclk_i) disable iff (rst_i)
      s_poll_read and (op_r == OP_SECTOR_ERASE) |-> ##[1:2] addr_o == addr_r;
  endproperty
  a_erase_addr: assert property (p_erase_addr) else $error("erase poll off sector");

  property p_final_data;
    @(posedge mclk_i) disable iff (rst_i)
      (state_r == S_FINAL && bus_done) |=> ##1 (done_o && !fail_o &&
        rdata_o == $past(bus_rdata, 2));
  endproperty
  a_final_data: assert property (p_final_data) else $error("data not from later read");

  property p_toggle_done;
    @(posedge mclk_i) disable iff (rst_i)
      (state_r == S_POLL2 && bus_done && toggle_same) |=> state_r == S_FINAL;
  endproperty
  a_toggle_done: assert property (p_toggle_done) else $error("toggle stop missed");

  property p_recheck_fail;
    @(posedge mclk_i) disable iff (rst_i)
      s_recheck_fail |=> state_r == S_RSTCMD;
  endproperty
  a_recheck_fail: assert property (p_recheck_fail) else $error("failed recheck kept on");

  property p_hold_restart;
    @(posedge mclk_i) disable iff (rst_i)
      (state_r == S_POLL2 && !pend_r && hold_i) |=> state_r == S_POLL1 && !pend_r;
  endproperty
  a_hold_restart: assert property (p_hold_restart) else $error("pause kept old sample");

  property p_reset_cmd;
    @(posedge mclk_i) disable iff (rst_i)
      s_recheck_fail |=> ##1 (bus_start_r && bus_write_r && bus_wdata_r == CMD_RESET);
  endproperty
  a_reset_cmd: assert property (p_reset_cmd) else $error("no reset after failure");
endmodule

// File: verification/flash_device_model.sv
`timescale 1ns/100ps
module flash_device_model (
  input wire logic mclk_i,
  input wire logic [flash_host_pkg::ADDR_W-1:0] addr_i,
  input wire logic [flash_host_pkg::DATA_W-1:0] dq_i,
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic [5:0] prot_sector_i,
  input wire logic [31:0] busy_cyc_i,
  output logic [flash_host_pkg::DATA_W-1:0] dq_o,
  output logic rb_low_o
);
  import flash_host_pkg::*;
  logic [DATA_W-1:0] mem [int];
  logic [DATA_W-1:0] drv;
  logic [DATA_W-1:0] last_q = 16'h0000;
  logic [DATA_W-1:0] pd = 16'h0000;
  logic [ADDR_W-1:0] pa = 18'h0_0000;
  logic erasing = 1'b0;
  logic chip = 1'b0;
  logic stuck = 1'b0;
  logic keep = 1'b0;
  logic tog6 = 1'b0;
  logic tog2 = 1'b0;
  int step = 0;
  int left = 0;
  int age = 0;

  // Unwritten words read as erased
  function automatic logic [DATA_W-1:0] arr(input logic [ADDR_W-1:0] a);
    return mem.exists(int'(a)) ? mem[int'(a)] : 16'hffff;
  endfunction

  // Busy pulls the shared line low; the pull-up gives ready
  assign rb_low_o = stuck || (left != 0);

  // Status word while busy, array word otherwise; released bus shows junk
  always_comb begin
    drv = arr(addr_i);
    if (rb_low_o) begin
      drv = 16'h0000;
      drv[7] = erasing ? 1'b0 : ~pd[7];
      drv[6] = tog6;
      drv[5] = stuck && (age >= 60);
      drv[2] = tog2;
    end
    dq_o = (!ce_n_i && !oe_n_i) ? drv : ~last_q;
  end

  // A completed read flips bit six while busy, and bit two too if erasing the sector read
  always @(posedge oe_n_i) begin
    if (!ce_n_i && rb_low_o) begin
      tog6 = ~tog6;
      if (erasing && (chip || addr_i[17:12] == pa[17:12]))
        tog2 = ~tog2;
    end
  end

  // Timer on the falling edge so the host never races it
  always @(negedge mclk_i) begin
    if (!ce_n_i && !oe_n_i)
      last_q = drv;
    if (stuck)
      age = age + 1;
    else if (left > 1)
      left = left - 1;
    else if (left == 1) begin
      left = 0;
      if (keep && !erasing)
        mem[int'(pa)] = pd & arr(pa);
      else if (keep)
        foreach (mem[k])
          if (chip ? k[17:12] != prot_sector_i : k[17:12] == pa[17:12])
            mem[k] = 16'hffff;
    end
  end

  // Command decoder; only the low byte matters for unlock and commands
  always @(posedge we_n_i) begin
    if (!ce_n_i && dq_i[7:0] == 8'hf0) begin
      step = 0;
      left = 0;
      stuck = 1'b0;
    end else if (!ce_n_i && !rb_low_o) begin
      case (step)
        0: step = (dq_i[7:0] == 8'haa) ? 1 : 0;
        1: step = (dq_i[7:0] == 8'h55) ? 2 : 0;
        2: step = (dq_i[7:0] == 8'ha0) ? 3 : ((dq_i[7:0] == 8'h80) ? 4 : 0);
        4: step = (dq_i[7:0] == 8'haa) ? 5 : 0;
        5: step = (dq_i[7:0] == 8'h55) ? 6 : 0;
        default: begin
          pa = addr_i;
          pd = dq_i;
          erasing = (step == 6);
          chip = (dq_i[7:0] == 8'h10);
          keep = (chip && erasing) || (addr_i[17:12] != prot_sector_i);
          left = keep ? int'(busy_cyc_i) : (erasing ? 10000 : 100);
          stuck = keep && !erasing && ((dq_i & ~arr(addr_i)) != 16'h0000);
          age = 0;
          step = 0;  // Busy from this strobe edge
        end
      endcase
    end
  end
endmodule

// File: verification/flash_status_poller_test.sv
`timescale 1ns/100ps
module flash_status_poller_test;
  import flash_host_pkg::*;
  typedef struct packed {
    op_t op;
    method_t m;
    logic [17:0] a;
    logic [15:0] d;
    logic [15:0] x;
    logic f;
    logic h;
  } step_t;
  // Odd rows run with a slow device, even rows with a prompt one
  localparam step_t TBL [0:14] = '{
    '{OP_READ, METHOD_DATA_POLL, 18'h0_1000, 16'h0000, 16'hffff, 1'b0, 1'b0},
    '{OP_PROGRAM, METHOD_DATA_POLL, 18'h0_1004, 16'h1234, 16'h1234, 1'b0, 1'b0},
    '{OP_PROGRAM, METHOD_TOGGLE, 18'h0_1008, 16'h00a5, 16'h00a5, 1'b0, 1'b0},
    '{OP_PROGRAM, METHOD_PIN, 18'h0_2000, 16'h5a5a, 16'h5a5a, 1'b0, 1'b0},
    '{OP_READ, METHOD_DATA_POLL, 18'h0_1004, 16'h0000, 16'h1234, 1'b0, 1'b0},
    '{OP_PROGRAM, METHOD_DATA_POLL, 18'h0_1004, 16'hffff, 16'h0000, 1'b1, 1'b0},
    '{OP_PROGRAM, METHOD_TOGGLE, 18'h0_1008, 16'h00ff, 16'h0000, 1'b1, 1'b0},
    '{OP_READ, METHOD_DATA_POLL, 18'h0_1004, 16'h0000, 16'h1234, 1'b0, 1'b0},
    '{OP_PROGRAM, METHOD_TOGGLE, 18'h3_f010, 16'h0000, 16'hffff, 1'b0, 1'b0},
    '{OP_PROGRAM, METHOD_DATA_POLL, 18'h3_f020, 16'h0080, 16'hffff, 1'b0, 1'b0},
    '{OP_SECTOR_ERASE, METHOD_DATA_POLL, 18'h3_f000, 16'h0000, 16'hffff, 1'b0, 1'b0},
    '{OP_SECTOR_ERASE, METHOD_TOGGLE, 18'h0_1000, 16'h0000, 16'hffff, 1'b0, 1'b1},
    '{OP_READ, METHOD_DATA_POLL, 18'h0_1008, 16'h0000, 16'hffff, 1'b0, 1'b0},
    '{OP_CHIP_ERASE, METHOD_DATA_POLL, 18'h0_2000, 16'h0000, 16'hffff, 1'b0, 1'b0},
    '{OP_READ, METHOD_DATA_POLL, 18'h0_2000, 16'h0000, 16'hffff, 1'b0, 1'b0}
  };
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  logic hold_i = 1'b0;
  op_t cmd_op_i = OP_READ;
  method_t cmd_method_i = METHOD_DATA_POLL;
  logic [ADDR_W-1:0] cmd_addr_i = 18'h0_0000;
  logic [DATA_W-1:0] cmd_data_i = 16'h0000;
  logic cmd_ready_o, done_o, fail_o, dq_oe_o, ce_n_o, oe_n_o, we_n_o, rb_low;
  logic [DATA_W-1:0] rdata_o, dq_o, flash_dq, dq_in;
  logic [ADDR_W-1:0] addr_o;
  int busy_cyc = 20;
  int failures = 0;
  int checks = 0;
  int nreads = 0;

  // Bus resolution: host drives while enabled, otherwise the device
  assign dq_in = dq_oe_o ? dq_o : flash_dq;

  flash_status_poller flash_status_poller_i (.mclk_i(mclk_i), .rst_i(rst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_op_i(cmd_op_i), .cmd_method_i(cmd_method_i),
    .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i), .hold_i(hold_i), .dq_i(dq_in),
    .ready_busy_n_pin_i(!rb_low), .cmd_ready_o(cmd_ready_o), .done_o(done_o),
    .fail_o(fail_o), .rdata_o(rdata_o), .addr_o(addr_o), .dq_o(dq_o), .dq_oe_o(dq_oe_o),
    .ce_n_o(ce_n_o), .oe_n_o(oe_n_o), .we_n_o(we_n_o));

  flash_device_model flash_device_model_i (.mclk_i(mclk_i), .addr_i(addr_o), .dq_i(dq_o),
    .ce_n_i(ce_n_o), .oe_n_i(oe_n_o), .we_n_i(we_n_o), .prot_sector_i(6'h3f),
    .busy_cyc_i(busy_cyc), .dq_o(flash_dq), .rb_low_o(rb_low));

  initial forever #5 mclk_i = ~mclk_i;

  always @(negedge oe_n_o) nreads++;

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // One request, optional pause in mid-poll, then the outcome
  task automatic run(input step_t s);
    int n;
    int k;
    cmd_valid_i <= 1'b1;
    cmd_op_i <= s.op;
    cmd_method_i <= s.m;
    cmd_addr_i <= s.a;
    cmd_data_i <= s.d;
    @(posedge mclk_i);
    while (cmd_ready_o !== 1'b1) @(posedge mclk_i);
    cmd_valid_i <= 1'b0;
    if (s.h) begin
      for (n = 0; n < 500 && rb_low !== 1'b1; n++) @(posedge mclk_i);
      hold_i <= 1'b1;
      repeat (20) @(posedge mclk_i);
      k = nreads;
      repeat (100) @(posedge mclk_i);
      check("reads while held", 16'(k), 16'(nreads));
      hold_i <= 1'b0;
    end
    for (n = 0; n < 20000 && done_o !== 1'b1; n++) @(posedge mclk_i);
    check("done", 16'h0001, {15'h0000, done_o});
    check("fail", {15'h0000, s.f}, {15'h0000, fail_o});
    if (!s.f)
      check("rdata", s.x, rdata_o);
  endtask

  initial begin
    repeat (6) @(posedge mclk_i);
    rst_i <= 1'b0;
    @(posedge mclk_i);
    check("idle pins", 16'h0007, {13'h0000, cmd_ready_o, ce_n_o, we_n_o});
    for (int i = 0; i < 15; i++) begin
      busy_cyc = i[0] ? 400 : 20;
      run(TBL[i]);
    end
    test_done();
  end

  // Hang guard, well beyond the longest protected erase
  initial begin
    repeat (60000) @(posedge mclk_i);
    failures++;
    $display("Error watchdog expected finish seen hang");
    test_done();
  end
endmodule
